// ===== hw/fpcu_top.sv
// fpcu_top: fp format conversion datapath with AHB-Lite control registers
// assumes issue port and bus share CLK; one op in flight, result two edges after issue
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module fpcu_top (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic ISSUE_VALID,
   input fpcu_pkg::fpcu_issue_t ISSUE,
   input wire logic FPU_USABLE,
   output logic ISSUE_READY,
   output logic RES_VALID,
   output fpcu_pkg::fpcu_result_t RES,
   output logic IRQ
);
   import fpcu_pkg::*;

   fpcu_state_t st, next_st;
   fpcu_kind_t kind, next_kind;
   logic [4:0] fmt, next_fmt;
   logic [4:0] dest, next_dest;
   logic [63:0] qa, next_qa;
   logic [63:0] qb, next_qb;
   fpcu_result_t res, next_res;
   logic [17:0] csr, next_csr;
   logic [2:0] ist, next_ist;
   logic [2:0] ien, next_ien;
   logic wp, next_wp;
   logic [7:0] wa, next_wa;
   logic [31:0] rdata, next_rdata;
   fpcu_num_t n;
   logic [6:0] sh;
   logic [64:0] rq;
   logic rinx;
   logic [63:0] d;
   logic [5:0] c;
   logic lov;
   logic trap;
   logic signed [13:0] be;
   logic signed [13:0] t;
   logic [4:0] en;

   function automatic fpcu_kind_t decode(input logic [31:0] i, input logic cu);
      logic [4:0] f;
      logic z;
      f = i[25:21];
      z = (i[20:16] == 5'h00);
      if (i[31:26] != FPCU_MAJOR) return K_RI;
      if (!cu) return K_CU;
      if (i[5:0] == FN_CVS && z && (f == FMT_D || f == FMT_W || f == FMT_L))
         return K_CVS;
      if (i[5:0] == FN_CVD && z && (f == FMT_S || f == FMT_W || f == FMT_L))
         return K_CVD;
      if (i[5:0] == FN_CVL && z && (f == FMT_S || f == FMT_D)) return K_CVL;
      if (i[5:0] == FN_PAIR && f == FMT_S) return K_PAIR;
      if (i[5:0] == FN_PL && z && f == FMT_PAIRED) return K_PL;
      return K_RI;
   endfunction

   function automatic logic [6:0] clz(input logic [63:0] v);
      logic [6:0] k;
      logic hit;
      k = 7'h00;
      hit = 1'b0;
      for (int i = 63; i >= 0; i--) begin
         if (v[i]) hit = 1'b1;
         else if (!hit) k = k + 7'h01;
      end
      return k;
   endfunction

   // every source is brought to sign, unbiased exponent and a magnitude with
   // its leading one at bit 63, so one rounder serves all targets
   function automatic fpcu_num_t unpack(input logic [4:0] f, input logic [63:0] a);
      fpcu_num_t r;
      logic [63:0] mag;
      logic [6:0] lz;
      logic [10:0] ex;
      logic [51:0] fr;
      logic [10:0] top;
      r = '0;
      if (f == FMT_W || f == FMT_L) begin
         r.sgn = (f == FMT_W) ? a[31] : a[63];
         mag = (f == FMT_W) ? {{32{a[31]}}, a[31:0]} : a;
         if (r.sgn) mag = -mag;
         lz = clz(mag);
         r.m = mag << lz;
         r.e = 14'sh003F - $signed({7'h00, lz});
         r.zero = (mag == 64'h0);
      end else begin
         if (f == FMT_D) begin
            r.sgn = a[63];
            ex = a[62:52];
            fr = a[51:0];
            top = 11'h7FF;
            r.e = $signed({3'h0, ex}) - BIAS_D;
         end else begin
            r.sgn = a[31];
            ex = {3'h0, a[30:23]};
            fr = {a[22:0], 29'h0};
            top = 11'h0FF;
            r.e = $signed({3'h0, ex}) - BIAS_S;
         end
         r.m = {1'b1, fr, 11'h000};
         r.zero = (ex == 11'h000) && (fr == 52'h0);
         r.den = (ex == 11'h000) && (fr != 52'h0);
         r.inf = (ex == top) && (fr == 52'h0);
         r.nan = (ex == top) && (fr != 52'h0);
         r.snan = r.nan && fr[51];
      end
      return r;
   endfunction

   // overflow lands on the largest finite value when rounding points inward
   function automatic logic [31:0] ovf_s(input logic s, input logic [1:0] m);
      if (m == RM_RZ || (m == RM_RP && s) || (m == RM_RM && !s)) return {s, MAX_S};
      return {s, INF_S};
   endfunction

   assign en = csr[CSR_EN_LSB +: 5];

   always_comb begin
      n = unpack((kind == K_PL) ? FMT_S : fmt, qa);
      t = 14'sh003F - n.e;
      unique case (kind)
         K_CVD: sh = SH_D;
         K_CVL: sh = (t < 14'sh0000) ? 7'h00 : ((t > 14'sh007F) ? 7'h7F : t[6:0]);
         default: sh = SH_S;
      endcase
   end

   fpcu_round #(.W(64)) u_round (
      .mag(n.m),
      .sh(sh),
      .sgn(n.sgn),
      .rm(csr[1:0]),
      .q(rq),
      .inx(rinx)
   );

   always_comb begin
      d = 64'h0;
      c = 6'h00;
      be = 14'sh0000;
      lov = (n.e > 14'sh003F) || rq[64] || (rq[63] && !(n.sgn && rq[62:0] == 63'h0));
      unique case (kind)
         K_PAIR: d = {qa[31:0], qb[31:0]};
         K_CVL: begin
            if (n.nan || n.inf || (!n.zero && !n.den && lov)) begin
               c[C_V] = 1'b1;
               d = DEF_LONG;
            end else if (n.den) begin
               c[C_E] = 1'b1;
            end else if (!n.zero) begin
               d = n.sgn ? -rq[63:0] : rq[63:0];
               c[C_I] = rinx;
            end
         end
         K_CVD: begin
            be = n.e + BIAS_D + $signed({13'h0000, rq[53]});
            if (n.nan) begin
               c[C_V] = n.snan;
               d = QNAN_D;
            end else if (n.inf) begin
               d = {n.sgn, 11'h7FF, 52'h0};
            end else if (n.zero) begin
               d = {n.sgn, 63'h0};
            end else if (n.den) begin
               c[C_E] = 1'b1;
            end else begin
               // 53 bits hold any single or word exactly, so rinx stays low there
               d = {n.sgn, be[10:0], rq[53] ? 52'h0 : rq[51:0]};
               c[C_I] = rinx;
            end
         end
         K_CVS, K_PL: begin
            be = n.e + BIAS_S + $signed({13'h0000, rq[24]});
            if (n.nan) begin
               c[C_V] = n.snan;
               d = {32'h0, QNAN_S};
            end else if (n.inf) begin
               d = {32'h0, n.sgn, INF_S};
            end else if (n.zero) begin
               d = {32'h0, n.sgn, 31'h0};
            end else if (n.den) begin
               c[C_E] = 1'b1;
            end else if (be >= 14'sh00FF) begin
               c[C_O] = 1'b1;
               c[C_I] = 1'b1;
               d = {32'h0, ovf_s(n.sgn, csr[1:0])};
            end else if (be <= 14'sh0000) begin
               // tiny results flush to signed zero rather than denormalise
               c[C_U] = 1'b1;
               c[C_I] = 1'b1;
               d = {32'h0, n.sgn, 31'h0};
            end else begin
               d = {32'h0, n.sgn, be[7:0], rq[24] ? 23'h0 : rq[22:0]};
               c[C_I] = rinx;
            end
         end
         default: d = 64'h0;
      endcase
      trap = c[C_E] || (|(c[4:0] & en));
   end

   always_comb begin
      next_st = st;
      next_kind = kind;
      next_fmt = fmt;
      next_dest = dest;
      next_qa = qa;
      next_qb = qb;
      next_res = res;
      unique case (st)
         ST_IDLE: begin
            if (ISSUE_VALID) begin
               next_kind = decode(ISSUE.instr, FPU_USABLE);
               next_fmt = ISSUE.instr[25:21];
               next_dest = ISSUE.instr[10:6];
               next_qa = ISSUE.src_a;
               next_qb = ISSUE.src_b;
               next_st = ST_CALC;
            end
         end
         ST_CALC: begin
            next_res.dest = dest;
            next_res.data = d;
            next_res.res_instr = (kind == K_RI);
            next_res.cop_unusable = (kind == K_CU);
            next_res.fp_trap = (kind != K_RI) && (kind != K_CU) && trap;
            next_res.wr = (kind != K_RI) && (kind != K_CU) && !trap;
            next_st = ST_RESP;
         end
         ST_RESP: next_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         st <= ST_IDLE;
         kind <= K_RI;
         fmt <= 5'h00;
         dest <= 5'h00;
         qa <= 64'h0;
         qb <= 64'h0;
         res <= '0;
      end else begin
         st <= next_st;
         kind <= next_kind;
         fmt <= next_fmt;
         dest <= next_dest;
         qa <= next_qa;
         qb <= next_qb;
         res <= next_res;
      end
   end

   assign ISSUE_READY = (st == ST_IDLE);
   assign RES_VALID = (st == ST_RESP);
   assign RES = res;

   // bus: writes land in the data phase; hardware updates are applied last so
   // a completing conversion wins over a software write in the same cycle
   always_comb begin
      logic take;
      logic [2:0] clr;
      logic [2:0] ev;
      take = HSEL && HTRANS[1] && HREADY;
      clr = 3'h0;
      ev = 3'h0;
      next_wp = take && HWRITE;
      next_wa = take ? HADDR[7:0] : wa;
      next_rdata = rdata;
      next_csr = csr;
      next_ien = ien;
      if (take && !HWRITE) begin
         unique case (HADDR[7:0])
            OFS_CSR: next_rdata = {14'h0000, csr};
            OFS_IRQ_ST: next_rdata = {29'h0, ist};
            OFS_IRQ_EN: next_rdata = {29'h0, ien};
            default: next_rdata = 32'h0;
         endcase
      end
      if (wp) begin
         unique case (wa)
            OFS_CSR: next_csr = HWDATA[17:0];
            OFS_IRQ_EN: next_ien = HWDATA[2:0];
            OFS_IRQ_CLR: clr = HWDATA[2:0];
            default: next_csr = csr;
         endcase
      end
      if (st == ST_CALC) begin
         ev[IRQ_RI] = (kind == K_RI);
         ev[IRQ_CU] = (kind == K_CU);
         ev[IRQ_TRAP] = (kind != K_RI) && (kind != K_CU) && trap;
         if (kind != K_RI && kind != K_CU) begin
            next_csr[CSR_CAUSE_LSB +: 6] = c;
            next_csr[CSR_FLAG_LSB +: 5] = next_csr[CSR_FLAG_LSB +: 5] | c[4:0];
         end
      end
      next_ist = (ist & ~clr) | ev;
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         csr <= CSR_RESET;
         ist <= 3'h0;
         ien <= 3'h0;
         wp <= 1'b0;
         wa <= 8'h00;
         rdata <= 32'h0;
      end else begin
         csr <= next_csr;
         ist <= next_ist;
         ien <= next_ien;
         wp <= next_wp;
         wa <= next_wa;
         rdata <= next_rdata;
      end
   end

   assign HRDATA = rdata;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign IRQ = |(ist & ien);

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);

   sequence s_take;
      ISSUE_VALID && ISSUE_READY;
   endsequence
   sequence s_done;
      (st == ST_CALC) ##1 RES_VALID;
   endsequence
   property p_lat;
      s_take |=> s_done;
   endproperty
   a_lat: assert property (p_lat) else $error("no result two edges after issue");
   property p_cvd_exact;
      RES_VALID && kind == K_CVD && (fmt == FMT_S || fmt == FMT_W) |-> !csr[CSR_CAUSE_LSB];
   endproperty
   a_cvd_exact: assert property (p_cvd_exact) else $error("inexact on exact widen");
   property p_cvd_set;
      RES_VALID && kind == K_CVD |-> csr[CSR_CAUSE_LSB + C_U +: 3] == 3'h0;
   endproperty
   a_cvd_set: assert property (p_cvd_set) else $error("bad cause on to-double");
   property p_cvl_flag;
      RES_VALID && kind == K_CVL && csr[CSR_CAUSE_LSB + C_V] |-> csr[CSR_FLAG_LSB + C_V];
   endproperty
   a_cvl_flag: assert property (p_cvl_flag) else $error("invalid flag not set");
   property p_cvl_dflt;
      RES_VALID && kind == K_CVL && csr[CSR_CAUSE_LSB + C_V] && !en[C_V]
         |-> RES.wr && RES.data == DEF_LONG;
   endproperty
   a_cvl_dflt: assert property (p_cvl_dflt) else $error("wrong default long");
   property p_trap;
      RES_VALID && RES.fp_trap |-> !RES.wr && !RES.res_instr;
   endproperty
   a_trap: assert property (p_trap) else $error("trapped result written");
   property p_pair;
      RES_VALID && kind == K_PAIR
         |-> RES.wr && RES.data == {qa[31:0], qb[31:0]} && csr[CSR_CAUSE_LSB +: 6] == 6'h00;
   endproperty
   a_pair: assert property (p_pair) else $error("pair move wrong");
   property p_cu;
      s_take ##0 (ISSUE.instr[31:26] == FPCU_MAJOR && !FPU_USABLE)
         |=> ##1 (RES_VALID && RES.cop_unusable && !RES.wr && !RES.fp_trap);
   endproperty
   a_cu: assert property (p_cu) else $error("unusable not first");
   property p_pl_dec;
      s_take ##0 (FPU_USABLE && ISSUE.instr[31:21] == {FPCU_MAJOR, FMT_PAIRED}
         && ISSUE.instr[20:16] == 5'h00 && ISSUE.instr[5:0] == FN_PL) |=> kind == K_PL;
   endproperty
   a_pl_dec: assert property (p_pl_dec) else $error("lower-half not decoded");
endmodule // fpcu_top

// ===== hw/fpcu_pkg.sv
// fpcu_pkg: constants and types of the fp format conversion unit
// assumes one core clock, an AHB-Lite register port and a pipeline issue port
// Contract
// - to-double converts source format, rounds, writes destination
// - single or word to double is exact
// - to-double signals only invalid, unimplemented, inexact
// - to-long converts to signed 64-bit, rounded
// - to-long infinity, NaN or range error flags invalid
// - invalid to-long traps if enabled, else writes maximum
// - coprocessor unusable and reserved instruction also raised
// - to-long signals invalid, unimplemented, inexact; range errors signal invalid
// - pair puts first low word high, second low
// - pair is a plain move, no arithmetic exception
// - to-single converts source format, rounds, writes destination
// - single results signal invalid, unimplemented, inexact, overflow, underflow
// - lower-half op converts low single of pair
// - lower-half decode: major, format 10110, zero, 101000
package fpcu_pkg;
   localparam logic [5:0] FPCU_MAJOR = 6'h11;
   localparam logic [4:0] FMT_S = 5'h10;
   localparam logic [4:0] FMT_D = 5'h11;
   localparam logic [4:0] FMT_W = 5'h14;
   localparam logic [4:0] FMT_L = 5'h15;
   localparam logic [4:0] FMT_PAIRED = 5'h16;
   localparam logic [5:0] FN_CVS = 6'h20;
   localparam logic [5:0] FN_CVD = 6'h21;
   localparam logic [5:0] FN_CVL = 6'h25;
   localparam logic [5:0] FN_PAIR = 6'h26;
   localparam logic [5:0] FN_PL = 6'h28;
   localparam logic [1:0] RM_RZ = 2'h1;
   localparam logic [1:0] RM_RP = 2'h2;
   localparam logic [1:0] RM_RM = 2'h3;
   // cause vector bit positions
   localparam int C_I = 0;
   localparam int C_U = 1;
   localparam int C_O = 2;
   localparam int C_Z = 3;
   localparam int C_V = 4;
   localparam int C_E = 5;
   // control/status field positions
   localparam int CSR_FLAG_LSB = 2;
   localparam int CSR_EN_LSB = 7;
   localparam int CSR_CAUSE_LSB = 12;
   localparam logic [17:0] CSR_RESET = 18'h00000;
   localparam logic [7:0] OFS_CSR = 8'h00;
   localparam logic [7:0] OFS_IRQ_ST = 8'h04;
   localparam logic [7:0] OFS_IRQ_EN = 8'h08;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h0C;
   localparam int IRQ_TRAP = 0;
   localparam int IRQ_RI = 1;
   localparam int IRQ_CU = 2;
   localparam logic [63:0] DEF_LONG = 64'h7FFF_FFFF_FFFF_FFFF;
   localparam logic [31:0] QNAN_S = 32'h7FBF_FFFF;
   localparam logic [63:0] QNAN_D = 64'h7FF7_FFFF_FFFF_FFFF;
   localparam logic [30:0] MAX_S = 31'h7F7F_FFFF;
   localparam logic [30:0] INF_S = 31'h7F80_0000;
   localparam logic signed [13:0] BIAS_S = 14'sh007F;
   localparam logic signed [13:0] BIAS_D = 14'sh03FF;
   localparam logic [6:0] SH_S = 7'h28;
   localparam logic [6:0] SH_D = 7'h0B;
   typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_RESP} fpcu_state_t;
   typedef enum logic [2:0] {K_CVS, K_CVD, K_CVL, K_PAIR, K_PL, K_RI, K_CU} fpcu_kind_t;
   typedef struct packed {
      logic [31:0] instr;
      logic [63:0] src_a;
      logic [63:0] src_b;
   } fpcu_issue_t;
   typedef struct packed {
      logic [4:0] dest;
      logic [63:0] data;
      logic wr;
      logic fp_trap;
      logic res_instr;
      logic cop_unusable;
   } fpcu_result_t;
   typedef struct packed {
      logic sgn;
      logic signed [13:0] e;
      logic [63:0] m;
      logic zero;
      logic inf;
      logic nan;
      logic snan;
      logic den;
   } fpcu_num_t;
endpackage

// ===== hw/fpcu_round.sv
// fpcu_round: aligns a normalised magnitude and rounds it to an integer
// assumes the caller registers the result; purely combinational
`timescale 1ns/1ns
module fpcu_round #(
   parameter int W = 64
) (
   input wire logic [W-1:0] mag,
   input wire logic [6:0] sh,
   input wire logic sgn,
   input wire logic [1:0] rm,
   output logic [W:0] q,
   output logic inx
);
   import fpcu_pkg::*;
   logic [2*W-1:0] wide;
   logic grd;
   logic stk;
   logic inc;
   if (W < 8 || W > 64) begin : g_bad_width
      $error("fpcu_round: W must lie in 8..64");
   end
   // the shift spans twice the width so guard and sticky fall out of one shifter
   always_comb begin
      wide = {mag, {W{1'b0}}} >> sh;
      grd = wide[W-1];
      stk = |wide[W-2:0];
      unique case (rm)
         RM_RZ: inc = 1'b0;
         RM_RP: inc = !sgn && (grd || stk);
         RM_RM: inc = sgn && (grd || stk);
         default: inc = grd && (stk || wide[W]);
      endcase
      q = {1'b0, wide[2*W-1:W]} + {{W{1'b0}}, inc};
      inx = grd || stk;
   end
endmodule // fpcu_round

// ===== verif/fpcu_issuer.sv
// fpcu_issuer: pipeline-side model that hands one conversion op at a time to the unit
// assumes the unit's issue handshake on clk; the bench calls issue() by hierarchy
`timescale 1ns/1ns
module fpcu_issuer (
   input wire logic clk,
   output logic issue_valid,
   output fpcu_pkg::fpcu_issue_t issue_q,
   output logic fpu_usable,
   input wire logic issue_ready
);
   import fpcu_pkg::*;
   initial begin
      issue_valid = 1'b0;
      issue_q = '0;
      fpu_usable = 1'b1;
   end
   // dly idle cycles first, so the unit sees both prompt and slow issue
   task automatic issue(input logic [31:0] instr, input logic [63:0] a, input logic [63:0] b,
                        input logic cu, input int dly);
      repeat (dly) @(posedge clk);
      @(posedge clk);
      // never runs in 16-register mode; operands always in the named format
      issue_valid <= 1'b1;
      issue_q <= {instr, a, b};
      fpu_usable <= cu;
      @(posedge clk);
      while (issue_ready !== 1'b1) @(posedge clk);
      issue_valid <= 1'b0;
      // released operands must not keep mirroring the last op
      issue_q <= ~issue_q;
   endtask
endmodule // fpcu_issuer

// ===== verif/testbench.sv
// testbench: drives the conversion unit through its issue port and AHB-Lite registers
// assumes fpcu_issuer as the pipeline side and one 125 MHz clock
`timescale 1ns/1ns
module testbench;
   import fpcu_pkg::*;
   localparam logic [63:0] INF_D = 64'h7FF0000000000000;
   logic clk, resetn, hsel, hwrite, hreadyout, hresp, issue_valid, fpu_usable;
   logic issue_ready, res_valid, irq, opcu;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [63:0] opb;
   fpcu_issue_t issue;
   fpcu_result_t res;
   int fail_count, n_tests;

   fpcu_top fpcu_top_inst (.CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .ISSUE_VALID(issue_valid),
      .ISSUE(issue), .FPU_USABLE(fpu_usable), .ISSUE_READY(issue_ready),
      .RES_VALID(res_valid), .RES(res), .IRQ(irq));
   fpcu_issuer fpcu_issuer_inst (.clk(clk), .issue_valid(issue_valid), .issue_q(issue),
      .fpu_usable(fpu_usable), .issue_ready(issue_ready));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk({63'h0, got}, {63'h0, exp});
   endtask

   // one single word transfer; waits on the slave's ready rather than assuming no wait states
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      ahb(1'b0, a, 32'h0, d);
      chk({32'h0, d}, {32'h0, exp});
      // the slave has no error path, so every response must be OKAY
      chk1(hresp, 1'b0);
   endtask

   function automatic logic [31:0] mk(input logic [4:0] fmt, input logic [5:0] fn);
      return {FPCU_MAJOR, fmt, 5'h00, 5'h02, 5'h07, fn};
   endfunction

   // control/status is rewritten first, so flags start clear and equal the new cause
   task automatic op(input logic [11:0] init, input logic [31:0] instr, input logic [63:0] a,
                     input logic [63:0] exp, input logic [3:0] fl, input logic [5:0] cause);
      wr(OFS_CSR, {20'h0, init});
      fpcu_issuer_inst.issue(instr, a, opb, opcu, n_tests % 3);
      @(posedge clk);
      #1;
      chk1(res_valid, 1'b1);
      chk({60'h0, res.wr, res.fp_trap, res.res_instr, res.cop_unusable}, {60'h0, fl});
      if (fl[3]) begin
         chk(res.data, exp);
         chk({59'h0, res.dest}, 64'h7);
      end
      rd_chk(OFS_CSR, {20'h0, init} | {25'h0, cause[4:0], 2'h0} | {14'h0, cause, 12'h0});
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      // every op needs about a dozen cycles, so this only fires on a hang
      fail_count++;
      end_sim();
   end

   initial begin
      logic [63:0] pos [4];
      logic [63:0] neg [4];
      pos = '{64'h2, 64'h2, 64'h3, 64'h2};
      neg = '{64'hFFFFFFFFFFFFFFFE, 64'hFFFFFFFFFFFFFFFE, 64'hFFFFFFFFFFFFFFFE, 64'hFFFFFFFFFFFFFFFD};
      fail_count = 0;
      n_tests = 0;
      resetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      opb = 64'h0;
      opcu = 1'b1;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      rd_chk(OFS_CSR, 32'h0);
      rd_chk(OFS_IRQ_EN, 32'h0);
      rd_chk(OFS_IRQ_ST, 32'h0);
      op(12'h0,mk(FMT_S,FN_CVD),64'h3F800000,64'h3FF0000000000000,4'h8,6'h0);
      op(12'h0,mk(FMT_W,FN_CVD),64'h7FFFFFFF,64'h41DFFFFFFFC00000,4'h8,6'h0);
      op(12'h0,mk(FMT_L,FN_CVD),64'h0020000000000001,64'h4340000000000000,4'h8,6'h1);
      op(12'h0,mk(FMT_S,FN_CVD),64'h1,64'h0,4'h4,6'h20);
      op(12'h0,mk(FMT_S,FN_CVD),64'h7FC00000,QNAN_D,4'h8,6'h10);
      op(12'h0,mk(FMT_S,FN_CVD),64'h7F800001,QNAN_D,4'h8,6'h0);
      for (int m = 0; m < 4; m++) begin
         op(12'(m),mk(FMT_D,FN_CVL),64'h4004000000000000,pos[m],4'h8,6'h1);
         op(12'(m),mk(FMT_D,FN_CVL),64'hC004000000000000,neg[m],4'h8,6'h1);
      end
      op(12'h0,mk(FMT_D,FN_CVL),INF_D,DEF_LONG,4'h8,6'h10);
      op(12'h0,mk(FMT_D,FN_CVL),64'h43E0000000000000,DEF_LONG,4'h8,6'h10);
      op(12'h0,mk(FMT_D,FN_CVL),64'hC3E0000000000000,64'h8000000000000000,4'h8,6'h0);
      op(12'h0,mk(FMT_S,FN_CVL),64'h3F800000,64'h1,4'h8,6'h0);
      opb = 64'hFFFFFFFFFF800000;
      op(12'hF80,mk(FMT_S,FN_PAIR),64'h123456787FC00001,64'h7FC00001FF800000,4'h8,6'h0);
      opb = 64'h0;
      op(12'h0,mk(FMT_D,FN_CVS),64'h3FF0000000000000,64'h3F800000,4'h8,6'h0);
      op(12'h0,mk(FMT_L,FN_CVS),64'h1000001,64'h4B800000,4'h8,6'h1);
      op(12'h0,mk(FMT_D,FN_CVS),64'h7FEFFFFFFFFFFFFF,64'h7F800000,4'h8,6'h5);
      op(12'h1,mk(FMT_D,FN_CVS),64'h7FEFFFFFFFFFFFFF,64'h7F7FFFFF,4'h8,6'h5);
      op(12'h0,mk(FMT_D,FN_CVS),64'h0170000000000000,64'h0,4'h8,6'h3);
      op(12'h0,mk(FMT_PAIRED,FN_PL),64'h7F8000003FC00000,64'h3FC00000,4'h8,6'h0);
      op(12'h0,mk(FMT_PAIRED,FN_PL)|32'h10000,64'h3FC00000,64'h0,4'h2,6'h0);
      op(12'h0,mk(FMT_S,FN_PL),64'h3FC00000,64'h0,4'h2,6'h0);
      op(12'h0,mk(FMT_S,FN_CVS),64'h3F800000,64'h0,4'h2,6'h0);
      op(12'h0,mk(FMT_W,FN_CVS)|32'h10000,64'h1,64'h0,4'h2,6'h0);
      op(12'h0,mk(FMT_W,FN_CVS),64'h1,64'h3F800000,4'h8,6'h0);
      op(12'h0,mk(FMT_D,FN_CVL)^32'h04000000,INF_D,64'h0,4'h2,6'h0);
      opcu = 1'b0;
      op(12'h800,mk(FMT_D,FN_CVL),INF_D,64'h0,4'h1,6'h0);
      opcu = 1'b1;
      rd_chk(OFS_IRQ_ST, 32'h7);
      wr(OFS_IRQ_CLR, 32'h7);
      rd_chk(OFS_IRQ_ST, 32'h0);
      op(12'h800,mk(FMT_D,FN_CVL),INF_D,64'h0,4'h4,6'h10);
      chk1(irq, 1'b0);
      rd_chk(OFS_IRQ_ST, 32'h1);
      wr(OFS_IRQ_EN, 32'h1);
      repeat (2) @(posedge clk);
      #1;
      chk1(irq, 1'b1);
      wr(OFS_IRQ_ST, 32'h0);
      rd_chk(OFS_IRQ_ST, 32'h1);
      wr(OFS_IRQ_CLR, 32'h1);
      repeat (2) @(posedge clk);
      #1;
      chk1(irq, 1'b0);
      rd_chk(OFS_IRQ_ST, 32'h0);
      rd_chk(OFS_IRQ_CLR, 32'h0);
      rd_chk(8'h10, 32'h0);
      rd_chk(OFS_IRQ_EN, 32'h1);
      end_sim();
   end
endmodule // testbench
